/* File: rtl/sbst_pkg.sv */
// Constants and types of the SRAM boundary-scan test port.
// Assumes a single system clock that oversamples the test clock pin.
package sbst_pkg;

	// Register lengths
	localparam int IR_LEN = 3;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 75;

	// Instruction codes
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDCODE = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ = 3'h2;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_BYPASS = 3'h7;

	// Pattern loaded in instruction capture
	localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;

	// Identification field values; revision and part fields are arbitrary
	localparam logic [3:0] ID_REVISION = 4'h0;
	localparam logic [4:0] ID_DEPTH_WIDE = 5'h07;
	localparam logic [4:0] ID_DEPTH_NARROW = 5'h08;
	localparam logic [4:0] ID_WIDTH_WIDE = 5'h04;
	localparam logic [4:0] ID_WIDTH_NARROW = 5'h03;
	localparam logic [5:0] ID_PART = 6'h00;
	// Maker code: arbitrary neutral value
	localparam logic [10:0] ID_MAKER = 11'h2A5;
	localparam logic ID_PRESENT = 1'h1;

	// Reset values and the mode-select run limit; pull-ups make idle pins read high
	localparam logic PIN_PULLUP = 1'h1;
	localparam logic [1:0] SYNC_RESET_CNT = 2'h0;
	localparam logic [2:0] TMS_RUN_RESET = 3'h0;
	localparam logic [2:0] TMS_RUN_LIMIT = 3'h5;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} sbst_state_t;

endpackage

/* File: rtl/sbst_tap.sv */
// Boundary-scan test access port of a pipelined SRAM, plus its pin filter.
// Assumes test pins are asynchronous to mclk, which runs far faster than
// the test clock; the pins' pull-ups are resolved outside this block.

// Three-stage pin filter; a change counts once stages two and three agree
module sbst_pin_sync #(
	parameter logic RESET_LEVEL = 1'h0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;

	// Stage one feeds only stage two, to keep metastability contained
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s1 <= RESET_LEVEL;
			s2 <= RESET_LEVEL;
			s3 <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule // sbst_pin_sync

module sbst_tap #(
	parameter bit WIDE = 1'h1,
	parameter logic [sbst_pkg::BSR_LEN-1:0] NC_MASK = '0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [sbst_pkg::BSR_LEN-1:0] ring_in,
	output logic tdo,
	output logic tdo_oe,
	output logic ring_hiz
);
	import sbst_pkg::*;

	localparam logic [ID_LEN-1:0] ID_VALUE = {ID_REVISION,
		WIDE ? ID_DEPTH_WIDE : ID_DEPTH_NARROW,
		WIDE ? ID_WIDTH_WIDE : ID_WIDTH_NARROW,
		ID_PART, ID_MAKER, ID_PRESENT};

	logic tck_f;
	logic tms_f;
	logic tdi_f;
	logic tck_d;
	logic tck_rise;
	logic tck_fall;
	sbst_state_t state;
	sbst_state_t next_state;
	logic [IR_LEN-1:0] ir;
	logic [IR_LEN-1:0] ir_sr;
	logic bypass;
	logic [ID_LEN-1:0] id_sr;
	logic [BSR_LEN-1:0] bsr;
	logic sel_bsr;
	logic sel_id;
	logic in_shift;
	logic next_tdo;
	logic [2:0] tms_run;
	logic checks_on;

	// Pin filters; idle mode select and data-in read high
	sbst_pin_sync #(.RESET_LEVEL(1'h0)) u_sync_tck (
		.mclk(mclk), .nrst(nrst), .pin(tck), .level(tck_f));
	sbst_pin_sync #(.RESET_LEVEL(PIN_PULLUP)) u_sync_tms (
		.mclk(mclk), .nrst(nrst), .pin(tms), .level(tms_f));
	sbst_pin_sync #(.RESET_LEVEL(PIN_PULLUP)) u_sync_tdi (
		.mclk(mclk), .nrst(nrst), .pin(tdi), .level(tdi_f));

	// Test clock edge finder
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tck_d <= 1'h0;
		end else begin
			tck_d <= tck_f;
		end
	end
	assign tck_rise = tck_f & ~tck_d;
	assign tck_fall = ~tck_f & tck_d;

	// Register selection by the held instruction; reserved codes bypass
	always_comb begin
		sel_bsr = 1'h0;
		sel_id = 1'h0;
		case (ir)
			INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE: sel_bsr = 1'h1;
			INS_IDCODE: sel_id = 1'h1;
			default: sel_bsr = 1'h0;
		endcase
	end

	// Controller next state
	always_comb begin
		case (state)
			ST_RESET: next_state = tms_f ? ST_RESET : ST_IDLE;
			ST_IDLE: next_state = tms_f ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_state = tms_f ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = tms_f ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_state = tms_f ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_state = tms_f ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_state = tms_f ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_state = tms_f ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: next_state = tms_f ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_state = tms_f ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_state = tms_f ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_state = tms_f ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_state = tms_f ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_state = tms_f ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_state = tms_f ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: next_state = tms_f ? ST_SEL_DR : ST_IDLE;
			default: next_state = ST_RESET;
		endcase
	end

	// Controller state; power-up lands in the reset state
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= ST_RESET;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// Instruction register and its shift stage
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ir <= INS_IDCODE;
			ir_sr <= INS_IDCODE;
		end else if (state == ST_RESET) begin
			ir <= INS_IDCODE;
		end else if (tck_rise) begin
			case (state)
				ST_CAP_IR: ir_sr <= {ir[IR_LEN-1:2], IR_CAPTURE_LSBS};
				ST_SHIFT_IR: ir_sr <= {tdi_f, ir_sr[IR_LEN-1:1]};
				ST_UPD_IR: ir <= ir_sr;
				default: ir <= ir;
			endcase
		end
	end

	// Bypass bit; cleared on capture so a chain test sees a known zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bypass <= 1'h0;
		end else if (tck_rise && !sel_bsr && !sel_id) begin
			if (state == ST_CAP_DR) begin
				bypass <= 1'h0;
			end else if (state == ST_SHIFT_DR) begin
				bypass <= tdi_f;
			end
		end
	end

	// Identification register, hard code captured then shifted
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			id_sr <= '0;
		end else if (tck_rise && sel_id) begin
			if (state == ST_CAP_DR) begin
				id_sr <= ID_VALUE;
			end else if (state == ST_SHIFT_DR) begin
				id_sr <= {tdi_f, id_sr[ID_LEN-1:1]};
			end
		end
	end

	// Boundary register; ring is taken raw, so a moving pin may read
	// either way, and unconnected cells capture zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bsr <= '0;
		end else if (tck_rise && sel_bsr) begin
			if (state == ST_CAP_DR) begin
				bsr <= ring_in & ~NC_MASK;
			end else if (state == ST_SHIFT_DR) begin
				bsr <= {tdi_f, bsr[BSR_LEN-1:1]};
			end
		end
	end

	// Data-out source: bottom bit of exactly one register
	assign in_shift = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
	always_comb begin
		if (state == ST_SHIFT_IR) begin
			next_tdo = ir_sr[0];
		end else if (sel_bsr) begin
			next_tdo = bsr[0];
		end else if (sel_id) begin
			next_tdo = id_sr[0];
		end else begin
			next_tdo = bypass;
		end
	end

	// Data-out drive, updated only on test clock falls
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tdo <= 1'h0;
			tdo_oe <= 1'h0;
		end else if (tck_fall) begin
			tdo <= next_tdo;
			tdo_oe <= in_shift;
		end
	end

	// Output high-Z request; touches nothing else of the memory path
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ring_hiz <= 1'h0;
		end else begin
			ring_hiz <= (ir == INS_EXTEST) || (ir == INS_SAMPLEZ);
		end
	end

	// Helper: rises seen in a row with mode select high
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tms_run <= TMS_RUN_RESET;
		end else if (tck_rise) begin
			if (!tms_f) begin
				tms_run <= TMS_RUN_RESET;
			end else if (tms_run != TMS_RUN_LIMIT) begin
				tms_run <= tms_run + 3'h1;
			end
		end
	end

	// Checks wait one clock past reset release, so history sampled
	// inside reset never reaches a property
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			checks_on <= 1'h0;
		end else begin
			checks_on <= 1'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst || !checks_on);

	chk_tdo_on_fall: assert property (
		$changed(tdo) |-> $past(tck_fall))
		else $error("data-out changed without a test clock fall");

	chk_five_ones_reset: assert property (
		(tms_run == TMS_RUN_LIMIT) |-> (state == ST_RESET))
		else $error("five high mode-select rises did not reach reset");

	chk_ir_reset_ident: assert property (
		(state == ST_RESET) |=> (ir == INS_IDCODE))
		else $error("instruction not ident after test reset");

	chk_ir_capture_lsbs: assert property (
		(tck_rise && state == ST_CAP_IR) |=> (ir_sr[1:0] == 2'h1))
		else $error("instruction capture did not load 01");

	chk_bypass_cleared: assert property (
		(tck_rise && state == ST_CAP_DR && !sel_bsr && !sel_id)
		|=> (bypass == 1'h0))
		else $error("bypass bit not cleared on capture");

	chk_hiz_by_instr: assert property (
		##1 (ring_hiz == ($past(ir) == INS_EXTEST || $past(ir) == INS_SAMPLEZ)))
		else $error("high-Z request disagrees with instruction");

	chk_oe_in_shift: assert property (
		tck_fall |=> (tdo_oe == $past(in_shift)))
		else $error("data-out enable wrong after fall");

	chk_ring_capture: assert property (
		(tck_rise && state == ST_CAP_DR && sel_bsr)
		|=> (bsr == ($past(ring_in) & ~NC_MASK)))
		else $error("boundary register did not capture ring");

	chk_shift_msb_in: assert property (
		(tck_rise && state == ST_SHIFT_DR && sel_bsr)
		|=> (bsr[BSR_LEN-1] == $past(tdi_f)))
		else $error("data-in did not enter top bit");

	chk_ident_capture: assert property (
		(tck_rise && state == ST_CAP_DR && sel_id) |=> (id_sr == ID_VALUE))
		else $error("ident register did not capture code");

	chk_ir_update_load: assert property (
		(tck_rise && state == ST_UPD_IR) |=> (ir == $past(ir_sr)))
		else $error("instruction not loaded at update");

	chk_ir_shift_msb: assert property (
		(tck_rise && state == ST_SHIFT_IR) |=> (ir_sr[IR_LEN-1] == $past(tdi_f)))
		else $error("data-in did not enter instruction top bit");

	chk_ident_shift_msb: assert property (
		(tck_rise && state == ST_SHIFT_DR && sel_id) |=> (id_sr[ID_LEN-1] == $past(tdi_f)))
		else $error("data-in did not enter ident top bit");

	chk_bypass_shift: assert property (
		(tck_rise && state == ST_SHIFT_DR && !sel_bsr && !sel_id) |=> (bypass == $past(tdi_f)))
		else $error("bypass bit did not take data-in");

	chk_tdo_ring_lsb: assert property (
		(tck_fall && state == ST_SHIFT_DR && sel_bsr) |=> (tdo == $past(bsr[0])))
		else $error("data-out not the boundary bottom bit");

endmodule // sbst_tap

/* File: bench/sbst_ctrl_model.sv */
// Behavioural scan controller that drives the test pins of the port.
// Assumes each step is entered just after an mclk rise; 8 mclk per tck.
module sbst_ctrl_model (
	input wire logic mclk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	// Pulled-up pins idle high; test clock parked low until a frame
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// One 32 ns tck: fall with new pin values, rise, then read data-out late
	task automatic step(input logic t, input logic d, output logic o, output logic oe);
		tck <= 1'h0;
		tms <= t;
		tdi <= d;
		repeat (4) @(posedge mclk);
		tck <= 1'h1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		// Undriven data-out reads as the inverse of its last level
		oe = tdo_oe;
		o = tdo_oe ? tdo : ~tdo;
		@(posedge mclk);
	endtask
endmodule // sbst_ctrl_model

/* File: bench/sbst_tap_tb.sv */
// Self-checking bench of the boundary-scan port through a controller model.
// Assumes the test pins are wired straight to the model; ring held static.
module sbst_tap_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sbst_pkg::*;

	localparam logic [74:0] RING = 75'h65AC3C30F0F966912F4;
	localparam logic [74:0] NCM = 75'h40000000000000000C1;
	localparam logic [31:0] ID_EXP = {ID_REVISION, ID_DEPTH_WIDE, ID_WIDTH_WIDE, ID_PART,
		ID_MAKER, ID_PRESENT};

	logic mclk = 1'h0;
	logic nrst = 1'h0;
	logic tck, tms, tdi, tdo, tdo_oe, ring_hiz;
	logic [74:0] ring_in = RING;
	logic [127:0] d;
	int n_fail = 0;
	int n_compared = 0;

	always #2 mclk = ~mclk;

	sbst_tap #(.WIDE(1'h1), .NC_MASK(NCM)) sbst_tap_inst (.mclk(mclk), .nrst(nrst), .tck(tck),
		.tms(tms), .tdi(tdi), .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe),
		.ring_hiz(ring_hiz));

	sbst_ctrl_model sbst_ctrl_model_inst (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe));

	task automatic close_out();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Idle to capture and shift, n bits LSB first, update, then two idle steps
	// so the update rise is taken before the caller looks at the result
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic o, oe;
		dout = '0;
		sbst_ctrl_model_inst.step(1'h1, 1'h1, o, oe);
		if (ir) begin
			sbst_ctrl_model_inst.step(1'h1, 1'h1, o, oe);
		end
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		for (int i = 0; i < n; i++) begin
			sbst_ctrl_model_inst.step(i == n - 1, din[i], o, oe);
			dout[i] = o;
			if (i == 0) cmp({127'h0, oe}, 128'h1);
		end
		sbst_ctrl_model_inst.step(1'h1, 1'h1, o, oe);
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		cmp({127'h0, oe}, 128'h0);
	endtask

	// Power-up state, then read the identification code straight away
	task automatic t_powerup();
		logic o, oe;
		cmp({127'h0, tdo_oe}, 128'h0);
		cmp({127'h0, ring_hiz}, 128'h0);
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		scan(1'h0, 32, '1, d);
		cmp({96'h0, d[31:0]}, {96'h0, ID_EXP});
	endtask

	// Capture pattern of the instruction register, then a bypass pass
	task automatic t_bypass();
		scan(1'h1, 3, {125'h0, INS_BYPASS}, d);
		cmp({126'h0, d[1:0]}, {126'h0, IR_CAPTURE_LSBS});
		scan(1'h0, 9, 128'hB5, d);
		cmp({119'h0, d[8:0]}, {119'h0, 8'hB5, 1'h0});
	endtask

	// Every ring-capturing code; trailing bits prove length and entry point
	task automatic t_ring();
		logic [2:0] codes [3];
		codes = '{INS_SAMPLE, INS_EXTEST, INS_SAMPLEZ};
		foreach (codes[k]) begin
			scan(1'h1, 3, {125'h0, codes[k]}, d);
			cmp({127'h0, ring_hiz}, {127'h0, codes[k] != INS_SAMPLE});
			scan(1'h0, 83, 128'h6C, d);
			cmp({53'h0, d[74:0]}, {53'h0, RING & ~NCM});
			cmp({120'h0, d[82:75]}, 128'h6C);
		end
	endtask

	// Five high mode-select rises from shift-IR, extest left loaded on the way
	task automatic t_test_reset();
		logic o, oe;
		logic [8:0] pat;
		pat = 9'h1F3;
		for (int i = 0; i < 9; i++) begin
			sbst_ctrl_model_inst.step(pat[i], 1'h0, o, oe);
		end
		sbst_ctrl_model_inst.step(1'h0, 1'h1, o, oe);
		cmp({127'h0, ring_hiz}, 128'h0);
		scan(1'h0, 32, '1, d);
		cmp({96'h0, d[31:0]}, {96'h0, ID_EXP});
	endtask

	// Main sequence; reset held two cycles, tck kept low a while after
	initial begin
		repeat (2) @(posedge mclk);
		nrst <= 1'h1;
		repeat (4) @(posedge mclk);
		t_powerup();
		t_bypass();
		t_ring();
		t_test_reset();
		close_out();
	end

	// Watchdog; the whole sequence needs about 13 us
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule // sbst_tap_tb
